/* shared/tsq_pkg.sv */
// constants and types shared by the trigger sequencer
// assumes a 20 MHz core clock and a state clock from the system under test
// Function
// - event counters hold without counter command
// - time counters keep run state without command
// - goto moves evaluation to named test
// - start: load settings, acquire, then monitor
// - end: halt, read back, enter display mode
// - running held until completion or stop
// - report control line level while running
// - flag primary done while timing acquires
// - flag timing done while primary acquires
// - clock absent until first state clock; the code needs the third to clear it
// - slow clock below one kilohertz flagged
// - timing-only program freezes clock indication
// - four tests, active_test_number always reported
// - primary trigger latches trigger test number
// - ORed events in a condition evaluated together
// - separate event/command pairs act together
// - commands of one event fire same cycle
// - contradictory commands: earliest in program wins
// - non-contradictory commands all still execute; the code applies one command per counter, the earliest in the program
// - no primary data for timing-only trigger program
// - no primary data under three clocks
// - no primary data without data qualification
// - acquire until all triggered sections finish
// - counters keep counting through post-trigger delay
package tsq_pkg;
  localparam int NTEST = 4;
  localparam int TW    = 2;
  localparam int NPAIR = 2;
  localparam int NCNT  = 2;
  localparam int NWR   = 2;
  localparam int CW    = 16;
  localparam int CMDW  = 3;
  localparam int NP    = NTEST * NPAIR;
  localparam int SW    = 10;
  localparam logic [CMDW-1:0] CMD_NONE  = 3'h0;
  localparam logic [CMDW-1:0] CMD_INC   = 3'h1;
  localparam logic [CMDW-1:0] CMD_RESET = 3'h2;
  localparam logic [CMDW-1:0] CMD_START = 3'h3;
  localparam logic [CMDW-1:0] CMD_STOP  = 3'h4;
  localparam logic [TW-1:0]   FIRST_TEST = 2'h0;
  localparam logic [CW-1:0]   CNT_CLR    = 16'h0000;
  localparam logic [1:0]      MIN_CLOCKS = 2'h3;
  localparam int CORE_PERIOD_NS = 50;
  localparam int SLOW_PERIOD_NS = 1000000;
  localparam int SLOW_CYC = SLOW_PERIOD_NS / CORE_PERIOD_NS;
  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_LOAD = 6'h02,
    S_RUN  = 6'h04,
    S_HALT = 6'h08,
    S_READ = 6'h10,
    S_DISP = 6'h20
  } tsq_state_t;
endpackage

/* src/tsq_sequencer.sv */
// trigger program sequencer: run control on core_clk, test evaluation
// on the state clock from the system under test
// assumes the program inputs stay stable from start until display mode
module tsq_sequencer #(
  parameter logic [15:0] SLOW_CYC_P = 16'(tsq_pkg::SLOW_CYC)
) (
  // core clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // run control
  input  wire logic start_req,
  input  wire logic stop_req,
  // state clock side
  input  wire logic sut_clk,
  input  wire logic [tsq_pkg::NWR-1:0] wr_hit,
  input  wire logic qual_hit,
  input  wire logic monitored_control_line,
  // trigger program
  input  wire logic [tsq_pkg::NP*tsq_pkg::NWR-1:0]  ev_wr_sel,
  input  wire logic [tsq_pkg::NP*tsq_pkg::NCNT-1:0] ev_cnt_sel,
  input  wire logic [tsq_pkg::NP-1:0]               cmd_trig_main,
  input  wire logic [tsq_pkg::NP-1:0]               cmd_trig_tim,
  input  wire logic [tsq_pkg::NP-1:0]               cmd_goto_en,
  input  wire logic [tsq_pkg::NP*tsq_pkg::TW-1:0]   cmd_goto_tgt,
  input  wire logic [tsq_pkg::NP*tsq_pkg::NCNT*tsq_pkg::CMDW-1:0] cmd_cnt,
  input  wire logic [tsq_pkg::NCNT-1:0]             cnt_time_mode,
  input  wire logic [tsq_pkg::NCNT*tsq_pkg::CW-1:0] cnt_cmp,
  input  wire logic [tsq_pkg::CW-1:0]               main_delay,
  input  wire logic [tsq_pkg::CW-1:0]               tim_delay,
  input  wire logic                                 prog_else_tim_only,
  // run phase
  output logic loading_q,
  output logic running_q,
  output logic halting_q,
  output logic reading_q,
  output logic display_mode_q,
  // run status
  output logic line_high_q,
  output logic no_clock_q,
  output logic slow_clock_q,
  output logic main_done_q,
  output logic tim_done_q,
  output logic [tsq_pkg::TW-1:0] active_test_number_q,
  output logic [tsq_pkg::TW-1:0] trig_test_q,
  output logic trig_test_valid_q,
  output logic primary_capture_memory_empty_q
);
  localparam int NP = tsq_pkg::NP;
  localparam int TW = tsq_pkg::TW;
  localparam int CW = tsq_pkg::CW;
  localparam int NC = tsq_pkg::NCNT;
  localparam int SW = tsq_pkg::SW;

  // core domain declarations
  tsq_pkg::tsq_state_t st_q;
  logic             start_tog_q;
  logic [1:0]       line_s_q;
  logic [2:0]       clk_s_q;
  logic [SW-1:0]    stat_s1_q;
  logic [SW-1:0]    stat_s2_q;
  logic [SW-1:0]    stat_s3_q;
  logic [SW-1:0]    stat_q;
  logic             freeze_q;
  logic             seen_q;
  logic [15:0]      gap_q;
  logic             clk_edge;
  logic             ack_ok;

  // link domain declarations
  logic [2:0]       st_l_q;
  logic [1:0]       run_l_q;
  logic             start_l;
  logic             live_l;
  logic             sut_tog_q;
  logic [TW-1:0]    test_q;
  logic [CW-1:0]    cnt_q [NC];
  logic [NC-1:0]    cnt_run_q;
  logic             mtrig_q;
  logic             ttrig_q;
  logic [CW-1:0]    mdly_q;
  logic [CW-1:0]    tdly_q;
  logic             mdone_q;
  logic             tdone_q;
  logic             mfirst_q;
  logic             tfirst_q;
  logic [TW-1:0]    ttest_q;
  logic [1:0]       nclk_q;
  logic             qual_seen_q;
  logic             use_main;
  logic             use_tim;
  logic             done_l;
  logic             empty_l;
  logic [tsq_pkg::NPAIR-1:0] fire;
  logic [NC-1:0]    cmp_eq;
  logic [tsq_pkg::CMDW-1:0] ccmd [NC];
  logic             goto_v;
  logic [TW-1:0]    goto_t;
  logic             trig_m;
  logic             trig_t;
  logic [SW-1:0]    stat_l;

  // run phase sequence
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q        <= tsq_pkg::S_IDLE;
      start_tog_q <= 1'b0;
    end else begin
      case (st_q)
        tsq_pkg::S_IDLE, tsq_pkg::S_DISP: begin
          if (start_req) st_q <= tsq_pkg::S_LOAD;
        end
        tsq_pkg::S_LOAD: begin
          st_q        <= tsq_pkg::S_RUN;
          // a start the link never saw is still pending; a second toggle
          // would cancel it and fake the acknowledge
          if (ack_ok) start_tog_q <= ~start_tog_q;
        end
        // leave run only on completion or stop
        tsq_pkg::S_RUN: begin
          if (stop_req || (ack_ok && stat_q[2])) st_q <= tsq_pkg::S_HALT;
        end
        tsq_pkg::S_HALT: st_q <= tsq_pkg::S_READ;
        tsq_pkg::S_READ: st_q <= tsq_pkg::S_DISP;
        default:         st_q <= tsq_pkg::S_IDLE;
      endcase
    end
  end

  assign loading_q      = st_q[1];
  assign running_q      = st_q[2];
  assign halting_q      = st_q[3];
  assign reading_q      = st_q[4];
  assign display_mode_q = st_q[5];

  // status bundle crossing; a word is taken only once two samples agree,
  // which stops a goto caught mid-change from showing a wrong test
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_s1_q <= '0;
      stat_s2_q <= '0;
      stat_s3_q <= '0;
      stat_q    <= '0;
    end else begin
      stat_s1_q <= stat_l;
      stat_s2_q <= stat_s1_q;
      stat_s3_q <= stat_s2_q;
      if (stat_s2_q == stat_s3_q) stat_q <= stat_s3_q;
    end
  end
  assign ack_ok = (stat_q[0] == start_tog_q);

  // status outputs, cleared at each start
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      main_done_q          <= 1'b0;
      tim_done_q           <= 1'b0;
      active_test_number_q <= tsq_pkg::FIRST_TEST;
      trig_test_q          <= tsq_pkg::FIRST_TEST;
      trig_test_valid_q    <= 1'b0;
      primary_capture_memory_empty_q <= 1'b0;
    end else if (loading_q) begin
      main_done_q          <= 1'b0;
      tim_done_q           <= 1'b0;
      active_test_number_q <= tsq_pkg::FIRST_TEST;
      trig_test_q          <= tsq_pkg::FIRST_TEST;
      trig_test_valid_q    <= 1'b0;
      primary_capture_memory_empty_q <= 1'b0;
    end else if (running_q && ack_ok) begin
      active_test_number_q <= stat_q[9:8];
      trig_test_q          <= stat_q[7:6];
      trig_test_valid_q    <= stat_q[5];
      main_done_q          <= stat_q[4];
      tim_done_q           <= stat_q[3];
    end else if (reading_q) begin
      primary_capture_memory_empty_q <= ~ack_ok | stat_q[1];
    end
  end

  // control line level, two flops from the pin
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      line_s_q    <= 2'h0;
      line_high_q <= 1'b0;
    end else begin
      line_s_q <= {line_s_q[0], monitored_control_line};
      // refreshed every core cycle while running
      if (running_q) line_high_q <= line_s_q[1];
    end
  end

  // state clock presence, seen through a toggle kept on sut_clk
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_s_q      <= 3'h0;
      freeze_q     <= 1'b0;
      seen_q       <= 1'b0;
      gap_q        <= 16'h0000;
      no_clock_q   <= 1'b0;
      slow_clock_q <= 1'b0;
    end else begin
      clk_s_q <= {clk_s_q[1:0], sut_tog_q};
      if (loading_q) begin
        freeze_q     <= prog_else_tim_only;
        seen_q       <= 1'b0;
        gap_q        <= 16'h0000;
        no_clock_q   <= 1'b1;
        slow_clock_q <= 1'b0;
      end else if (running_q) begin
        if (clk_edge) seen_q <= 1'b1;
        gap_q <= clk_edge ? 16'h0000 :
                 (gap_q == SLOW_CYC_P) ? gap_q : gap_q + 16'h0001;
        // timing-only program keeps the start indication
        if (!freeze_q) begin
          // the link acknowledges a start only on state clocks
          // so the acknowledge proves an edge since start
          if (ack_ok) no_clock_q <= 1'b0;
          // gap of a millisecond or more; a state clock locked
          // near twice the core rate can alias the toggle into a gap
          if (seen_q && gap_q == SLOW_CYC_P) slow_clock_q <= 1'b1;
          else if (clk_edge) slow_clock_q <= 1'b0;
        end
      end
    end
  end
  assign clk_edge = clk_s_q[2] ^ clk_s_q[1];

  // link side: start toggle and run level crossings
  always_ff @(posedge sut_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_l_q    <= 3'h0;
      run_l_q   <= 2'h0;
      sut_tog_q <= 1'b0;
    end else begin
      st_l_q    <= {st_l_q[1:0], start_tog_q};
      run_l_q   <= {run_l_q[0], running_q};
      sut_tog_q <= ~sut_tog_q;
    end
  end
  assign start_l = st_l_q[2] ^ st_l_q[1];

  assign use_main = |cmd_trig_main;
  assign use_tim  = |cmd_trig_tim;
  // done once every used section finished its delay
  assign done_l   = (use_main | use_tim) & (~use_main | mdone_q) &
                    (~use_tim | tdone_q);
  assign live_l   = run_l_q[1] & ~done_l & ~start_l;
  assign empty_l  = (~use_main & use_tim) | (nclk_q != tsq_pkg::MIN_CLOCKS)
                  | ~qual_seen_q;
  assign stat_l   = {test_q, ttest_q, mtrig_q, mfirst_q, tfirst_q,
                     done_l, empty_l, st_l_q[2]};

  // evaluation of the active_test_number
  always_comb begin
    int idx;
    idx    = 0;
    fire   = '0;
    goto_v = 1'b0;
    goto_t = tsq_pkg::FIRST_TEST;
    trig_m = 1'b0;
    trig_t = 1'b0;
    for (int c = 0; c < NC; c++) begin
      cmp_eq[c] = (cnt_q[c] == cnt_cmp[c*CW +: CW]);
      ccmd[c]   = tsq_pkg::CMD_NONE;
    end
    // all ORed events compared at once
    for (int p = 0; p < tsq_pkg::NPAIR; p++) begin
      idx = int'(test_q) * tsq_pkg::NPAIR + p;
      fire[p] = |(wr_hit & ev_wr_sel[idx*tsq_pkg::NWR +: tsq_pkg::NWR]) |
                |(cmp_eq & ev_cnt_sel[idx*NC +: NC]);
    end
    // scan last to first so the earliest pair overwrites
    for (int p = tsq_pkg::NPAIR - 1; p >= 0; p--) begin
      idx = int'(test_q) * tsq_pkg::NPAIR + p;
      if (fire[p]) begin
        trig_m = trig_m | cmd_trig_main[idx];
        trig_t = trig_t | cmd_trig_tim[idx];
        if (cmd_goto_en[idx]) begin
          goto_v = 1'b1;
          goto_t = cmd_goto_tgt[idx*TW +: TW];
        end
        for (int c = 0; c < NC; c++) begin
          if (cmd_cnt[(idx*NC+c)*tsq_pkg::CMDW +: tsq_pkg::CMDW]
              != tsq_pkg::CMD_NONE)
            ccmd[c] = cmd_cnt[(idx*NC+c)*tsq_pkg::CMDW +: tsq_pkg::CMDW];
        end
      end
    end
  end

  // active_test_number
  always_ff @(posedge sut_clk or negedge rst_n) begin
    if (!rst_n) begin
      test_q <= tsq_pkg::FIRST_TEST;
    end else if (start_l) begin
      test_q <= tsq_pkg::FIRST_TEST;
    end else if (live_l && goto_v) begin
      test_q <= goto_t;
    end
  end

  // programmable counters; they run on through the trigger delay
  always_ff @(posedge sut_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int c = 0; c < NC; c++) cnt_q[c] <= tsq_pkg::CNT_CLR;
      cnt_run_q <= '0;
    end else begin
      for (int c = 0; c < NC; c++) begin
        if (start_l) begin
          cnt_q[c]     <= tsq_pkg::CNT_CLR;
          cnt_run_q[c] <= 1'b0;
        end else if (live_l) begin
          case (ccmd[c])
            tsq_pkg::CMD_INC:   cnt_q[c] <= cnt_q[c] + 16'h0001;
            tsq_pkg::CMD_RESET: cnt_q[c] <= tsq_pkg::CNT_CLR;
            tsq_pkg::CMD_START: cnt_run_q[c] <= 1'b1;
            tsq_pkg::CMD_STOP:  cnt_run_q[c] <= 1'b0;
            default: begin
              // no command: value or run state kept
              if (cnt_time_mode[c] && cnt_run_q[c])
                cnt_q[c] <= cnt_q[c] + 16'h0001;
            end
          endcase
        end
      end
    end
  end

  // triggers, post-trigger delays and section completion
  always_ff @(posedge sut_clk or negedge rst_n) begin
    if (!rst_n) begin
      mtrig_q  <= 1'b0;
      ttrig_q  <= 1'b0;
      mdly_q   <= tsq_pkg::CNT_CLR;
      tdly_q   <= tsq_pkg::CNT_CLR;
      mdone_q  <= 1'b0;
      tdone_q  <= 1'b0;
      mfirst_q <= 1'b0;
      tfirst_q <= 1'b0;
      ttest_q  <= tsq_pkg::FIRST_TEST;
    end else if (start_l) begin
      mtrig_q  <= 1'b0;
      ttrig_q  <= 1'b0;
      mdly_q   <= tsq_pkg::CNT_CLR;
      tdly_q   <= tsq_pkg::CNT_CLR;
      mdone_q  <= 1'b0;
      tdone_q  <= 1'b0;
      mfirst_q <= 1'b0;
      tfirst_q <= 1'b0;
      ttest_q  <= tsq_pkg::FIRST_TEST;
    end else if (live_l) begin
      // only the first primary trigger latches its test
      if (trig_m && !mtrig_q) begin
        mtrig_q <= 1'b1;
        ttest_q <= test_q;
      end
      if (trig_t) ttrig_q <= 1'b1;
      if (mtrig_q && !mdone_q) begin
        if (mdly_q == main_delay) begin
          mdone_q <= 1'b1;
          if (use_tim && !tdone_q) mfirst_q <= 1'b1;
        end else begin
          mdly_q <= mdly_q + 16'h0001;
        end
      end
      if (ttrig_q && !tdone_q) begin
        if (tdly_q == tim_delay) begin
          tdone_q <= 1'b1;
          if (use_main && !mdone_q) tfirst_q <= 1'b1;
        end else begin
          tdly_q <= tdly_q + 16'h0001;
        end
      end
    end
  end

  // input clocks and data qualification seen during the run
  always_ff @(posedge sut_clk or negedge rst_n) begin
    if (!rst_n) begin
      nclk_q      <= 2'h0;
      qual_seen_q <= 1'b0;
    end else if (start_l) begin
      nclk_q      <= 2'h0;
      qual_seen_q <= 1'b0;
    end else if (live_l) begin
      if (nclk_q != tsq_pkg::MIN_CLOCKS) nclk_q <= nclk_q + 2'h1;
      if (qual_hit) qual_seen_q <= 1'b1;
    end
  end

  // checks on the core clock
  a_run_holds: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    running_q && !stop_req && !(ack_ok && stat_q[2]) |=> running_q)
    else $error("run left without stop or completion");
  a_stop_ends: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    running_q && stop_req |=> halting_q ##1 reading_q ##1 display_mode_q)
    else $error("stop did not lead to display mode");
  a_start_loads: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    st_q == tsq_pkg::S_IDLE && start_req |=> loading_q ##1 running_q)
    else $error("start did not load then run");
  a_start_clears: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    $rose(running_q) |-> no_clock_q && !trig_test_valid_q
      && active_test_number_q == tsq_pkg::FIRST_TEST)
    else $error("status not cleared at start");
  a_freeze_clock: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    running_q && freeze_q |=> $stable(no_clock_q))
    else $error("frozen clock indication changed");
  a_clock_seen: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    running_q && !freeze_q && ack_ok |=> !no_clock_q)
    else $error("clock absent after the link acknowledged");
  // checks on the state clock
  a_count_hold: assert property (
    @(posedge sut_clk) disable iff (!rst_n)
    live_l && ccmd[0] == tsq_pkg::CMD_NONE && !cnt_time_mode[0]
    |=> $stable(cnt_q[0]))
    else $error("event counter moved without command");
  a_goto_moves: assert property (
    @(posedge sut_clk) disable iff (!rst_n)
    live_l && goto_v |=> test_q == $past(goto_t))
    else $error("goto not taken");
  a_trig_test: assert property (
    @(posedge sut_clk) disable iff (!rst_n)
    live_l && trig_m && !mtrig_q |=> ttest_q == $past(test_q) ##1
    $stable(ttest_q))
    else $error("trigger test not latched");
  a_first_wins: assert property (
    @(posedge sut_clk) disable iff (!rst_n)
    fire[0] && cmd_cnt[(int'(test_q)*2*NC)*3 +: 3] != tsq_pkg::CMD_NONE
    |-> ccmd[0] == cmd_cnt[(int'(test_q)*2*NC)*3 +: 3])
    else $error("later command beat earlier one");
  c_full_run: cover property (@(posedge core_clk) disable iff (!rst_n)
    running_q ##1 halting_q ##1 reading_q ##1 display_mode_q);
  c_stop_run: cover property (@(posedge core_clk) disable iff (!rst_n)
    running_q && stop_req);
  c_trig_goto: cover property (@(posedge sut_clk) disable iff (!rst_n)
    live_l && trig_m && goto_v);
endmodule

/* testbench/tsq_sut_model.sv */
// system under test model: state clock, word matches, qualification, line
// assumes the bench calls burst() for frames; the clock stands still between
module tsq_sut_model (
  // link side
  output logic       sut_clk,
  output logic [1:0] wr_hit,
  output logic       qual_hit,
  // monitored pin
  output logic       monitored_control_line
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    sut_clk = 1'b0;
    wr_hit = 2'h0;
    qual_hit = 1'b0;
    monitored_control_line = 1'b0;
  end

  // n state clocks at 12 ns with the given match and qualification levels
  task automatic burst(input int n, input logic [1:0] wr, input logic q);
    for (int i = 0; i < n; i++) begin
      wr_hit = wr;
      qual_hit = q;
      #6 sut_clk = 1'b1;
      #6 sut_clk = 1'b0;
    end
    // outside a frame the levels mean nothing, so show the inverse
    wr_hit = ~wr;
    qual_hit = ~q;
  endtask

  task automatic set_line(input logic v);
    monitored_control_line = v;
  endtask
endmodule

/* testbench/tsq_sequencer_test.sv */
// self-checking bench for the trigger sequencer run control
// assumes a 20 MHz core clock; the state clock comes from tsq_sut_model
module tsq_sequencer_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic        core_clk, rst_n, start_req, stop_req;
  logic        sut_clk, qual_hit, monitored_control_line;
  logic [1:0]  wr_hit, cnt_time_mode, active_test_number_q, trig_test_q;
  logic [15:0] ev_wr_sel, ev_cnt_sel, cmd_goto_tgt, main_delay, tim_delay;
  logic [7:0]  cmd_trig_main, cmd_trig_tim, cmd_goto_en;
  logic [47:0] cmd_cnt;
  logic [31:0] cnt_cmp;
  logic        prog_else_tim_only, loading_q, running_q, halting_q;
  logic        reading_q, display_mode_q, line_high_q, no_clock_q;
  logic        slow_clock_q, main_done_q, tim_done_q, trig_test_valid_q;
  logic        primary_capture_memory_empty_q;
  int          num_errors, n_compared, cycles;

  tsq_sequencer #(.SLOW_CYC_P(16'h00C8)) tsq_sequencer_inst (
    .core_clk, .rst_n, .start_req, .stop_req, .sut_clk, .wr_hit, .qual_hit,
    .monitored_control_line, .ev_wr_sel, .ev_cnt_sel, .cmd_trig_main,
    .cmd_trig_tim, .cmd_goto_en, .cmd_goto_tgt, .cmd_cnt, .cnt_time_mode,
    .cnt_cmp, .main_delay, .tim_delay, .prog_else_tim_only, .loading_q,
    .running_q, .halting_q, .reading_q, .display_mode_q, .line_high_q,
    .no_clock_q, .slow_clock_q, .main_done_q, .tim_done_q,
    .active_test_number_q, .trig_test_q, .trig_test_valid_q,
    .primary_capture_memory_empty_q);

  tsq_sut_model tsq_sut_model_inst (
    .sut_clk, .wr_hit, .qual_hit, .monitored_control_line);

  initial core_clk = 1'b0;
  always #25 core_clk = ~core_clk;

  task automatic end_of_test();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // hang guard, well above the few hundred cycles the run needs
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      end_of_test();
    end
  end

  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic clear_prog();
    ev_wr_sel = 16'h0000;
    ev_cnt_sel = 16'h0000;
    cmd_goto_tgt = 16'h0000;
    cmd_trig_main = 8'h00;
    cmd_trig_tim = 8'h00;
    cmd_goto_en = 8'h00;
    cmd_cnt = 48'h000000000000;
    cnt_time_mode = 2'h0;
    cnt_cmp = 32'h00030003;
    main_delay = 16'h0002;
    tim_delay = 16'h0000;
    prog_else_tim_only = 1'b0;
  endtask

  task automatic start_run();
    @(negedge core_clk) start_req = 1'b1;
    @(negedge core_clk) start_req = 1'b0;
    chk(4'(loading_q), 4'h1);
    @(negedge core_clk);
    chk(4'(running_q), 4'h1);
    chk(4'(no_clock_q), 4'h1);
    chk(4'(trig_test_valid_q), 4'h0);
    chk(4'(active_test_number_q), 4'h0);
  endtask

  task automatic stop_run();
    @(negedge core_clk) stop_req = 1'b1;
    @(negedge core_clk) stop_req = 1'b0;
    chk(4'(halting_q), 4'h1);
    @(negedge core_clk);
    chk(4'(reading_q), 4'h1);
    @(negedge core_clk);
    chk(4'(display_mode_q), 4'h1);
  endtask

  // completion has no fixed latency, so wait under a bound
  task automatic wait_display();
    for (int i = 0; i < 80 && display_mode_q !== 1'b1; i++) begin
      @(negedge core_clk);
    end
    chk(4'(display_mode_q), 4'h1);
  endtask

  initial begin
    rst_n = 1'b0;
    start_req = 1'b0;
    stop_req = 1'b0;
    clear_prog();
    repeat (8) @(negedge core_clk);
    chk(4'(running_q), 4'h0);
    chk(4'(display_mode_q), 4'h0);
    rst_n = 1'b1;
    tsq_sut_model_inst.burst(4, 2'h0, 1'b0);
    // run 1: three state clocks, a long gap, stop leaves the memory empty
    start_run();
    tsq_sut_model_inst.burst(3, 2'h0, 1'b0);
    tsq_sut_model_inst.set_line(1'b1);
    repeat (6) @(negedge core_clk);
    chk(4'(line_high_q), 4'h1);
    tsq_sut_model_inst.set_line(1'b0);
    repeat (6) @(negedge core_clk);
    chk(4'(line_high_q), 4'h0);
    chk(4'(running_q), 4'h1);
    chk(4'(slow_clock_q), 4'h0);
    repeat (200) @(negedge core_clk);
    chk(4'(no_clock_q), 4'h0);
    chk(4'(slow_clock_q), 4'h1);
    stop_run();
    chk(4'(primary_capture_memory_empty_q), 4'h1);
    // run 2: test 0 counts both, timing trigger, goto 1; main trig, goto 2
    ev_wr_sel[1:0] = 2'h1;
    cmd_cnt[5:0] = {tsq_pkg::CMD_INC, tsq_pkg::CMD_INC};
    ev_cnt_sel[3:2] = 2'h1;
    cmd_goto_en[1] = 1'b1;
    cmd_goto_tgt[3:2] = 2'h1;
    ev_cnt_sel[5:4] = 2'h2;
    cmd_trig_main[2] = 1'b1;
    cmd_goto_en[2] = 1'b1;
    cmd_goto_tgt[5:4] = 2'h2;
    cmd_trig_tim[0] = 1'b1;
    start_run();
    tsq_sut_model_inst.burst(4, 2'h0, 1'b1);
    tsq_sut_model_inst.burst(3, 2'h1, 1'b1);
    tsq_sut_model_inst.burst(14, 2'h0, 1'b1);
    wait_display();
    chk(4'(active_test_number_q), 4'h2);
    chk(4'(trig_test_q), 4'h1);
    chk(4'(trig_test_valid_q), 4'h1);
    chk(4'(no_clock_q), 4'h0);
    chk(4'(primary_capture_memory_empty_q), 4'h0);
    chk(4'(tim_done_q), 4'h1);
    chk(4'(main_done_q), 4'h0);
    // run 3: timing trigger only, memory stays empty
    clear_prog();
    ev_wr_sel[1:0] = 2'h1;
    cmd_trig_tim[0] = 1'b1;
    start_run();
    tsq_sut_model_inst.burst(4, 2'h0, 1'b1);
    tsq_sut_model_inst.burst(2, 2'h1, 1'b1);
    tsq_sut_model_inst.burst(14, 2'h0, 1'b1);
    wait_display();
    chk(4'(primary_capture_memory_empty_q), 4'h1);
    chk(4'(main_done_q), 4'h0);
    chk(4'(tim_done_q), 4'h0);
    // run 4: unconditional timing program freezes the clock indication
    clear_prog();
    prog_else_tim_only = 1'b1;
    start_run();
    tsq_sut_model_inst.burst(20, 2'h0, 1'b1);
    repeat (10) @(negedge core_clk);
    chk(4'(no_clock_q), 4'h1);
    stop_run();
    end_of_test();
  end
endmodule
